// file: design/gat_pkg.sv
// package for the graphics address translation block
// assumes a single 20 MHz clock domain and no register bus
package gat_pkg;
  // ==========================================================
  // geometry
  // ==========================================================
  localparam int PAGE_SHIFT     = 12;
  localparam int LOG_ADDR_W     = 32;
  localparam int PHYS_ADDR_W    = 36;
  localparam int ENTRY_BYTES    = 4;
  localparam int ENTRY_SHIFT    = 2;
  localparam int GLOBAL_PAGES   = 128;
  localparam int PROCESS_PAGES  = 512;
  localparam int ENTRIES_PER_PG = 1024;
  localparam int GLOBAL_ENTRIES = GLOBAL_PAGES * ENTRIES_PER_PG;
  localparam int PROCESS_ENTRIES = PROCESS_PAGES * ENTRIES_PER_PG;
  localparam int GLOBAL_IDX_W   = 17;
  localparam int PROCESS_IDX_W  = 19;
  localparam int FRAME_W        = PHYS_ADDR_W - PAGE_SHIFT;
  localparam int ENTRY_W        = 32;
  localparam int CLIENT_W       = 4;
  localparam int SELECT_W       = 6;
  // ==========================================================
  // entry fields (valid bit, snoop bit, frame field)
  // ==========================================================
  localparam int ENT_VALID      = 0;
  localparam int ENT_SNOOP      = 1;
  localparam int ENT_FRAME_LO   = 12;
  localparam int ENT_FRAME_HI   = 31;
  localparam logic [PHYS_ADDR_W-1:0] STOLEN_TABLE_OFFSET = 36'h0_0000_0000;
  // ==========================================================
  // table select control bit positions
  // ==========================================================
  localparam int SEL_RENDER_DATA = 0;
  localparam int SEL_SAMPLER     = 1;
  localparam int SEL_RING        = 2;
  localparam int SEL_VERTEX      = 3;
  localparam int SEL_INDIRECT    = 4;
  localparam int SEL_BATCH       = 5;
  // ==========================================================
  // clients
  // ==========================================================
  typedef enum logic [CLIENT_W-1:0] {
    GAT_CL_HOST, GAT_CL_DISPLAY, GAT_CL_OVERLAY, GAT_CL_CURSOR,
    GAT_CL_RING, GAT_CL_BATCH, GAT_CL_INDIRECT, GAT_CL_CONSTANT,
    GAT_CL_MEDIA, GAT_CL_VERTEX, GAT_CL_SAMPLER, GAT_CL_RENDER,
    GAT_CL_DEPTH, GAT_CL_BLIT, GAT_CL_STORE_IMM, GAT_CL_PIPE_SYNC
  } gat_client_t;
endpackage

// file: design/gat_fetch_if.sv
// interface between the translator and its entry fetch unit
// assumes one clock, shared with both modules
`timescale 1ns/1ps
interface gat_fetch_if;
  import gat_pkg::*;
  logic                   req;
  logic [PHYS_ADDR_W-1:0] addr;
  logic                   done;
  logic [ENTRY_W-1:0]     entry;
  modport master (output req, output addr, input done, input entry);
  modport slave  (input req, input addr, output done, output entry);
endinterface

// file: design/gat_entry_fetch.sv
// entry fetch unit: one 4-byte table read from main memory per request
// assumes the memory path answers with a one-cycle valid pulse
`timescale 1ns/1ps
module gat_entry_fetch
  import gat_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      reset,
  gat_fetch_if.slave                     fch,
  output logic                           memReq,
  output logic [PHYS_ADDR_W-1:0]         memAddr,
  input  wire logic                      memValid,
  input  wire logic [ENTRY_W-1:0]        memData
);
  logic busy_q;
  logic done_q;
  logic [ENTRY_W-1:0] entry_q;
  // ==========================================================
  // single outstanding read
  // ==========================================================
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_q  <= 1'b0;
      memReq  <= 1'b0;
      memAddr <= '0;
      done_q  <= 1'b0;
      entry_q <= '0;
    end else begin
      done_q <= 1'b0;
      memReq <= 1'b0;
      if (!busy_q && fch.req) begin
        busy_q  <= 1'b1;
        memReq  <= 1'b1;
        memAddr <= fch.addr;
      end else if (busy_q && memValid) begin
        busy_q  <= 1'b0;
        done_q  <= 1'b1;
        entry_q <= memData;
      end
    end
  end
  assign fch.done  = done_q;
  assign fch.entry = entry_q;
endmodule // gat_entry_fetch

// file: design/gat_translate.sv
// graphics address translation: logical page to physical page via tables
// assumes entries live in main memory, reached by a single read port
// What this block does
// - translate logical address to 4KB physical page
// - tables are 4-byte entries in memory
// - global table at most 128 pages
// - process table at most 512 pages
// - disabled process table falls back to global
// - host and display always use global table
// - global table base at stolen offset zero
// - global entries updated via aperture or command
// - all base addresses are physical, used untranslated
// - valid entry maps unsnooped or snooped memory
// - select bits 2,5,4 for ring,batch,indirect
// - select bits 3,1,0 vertex,sampler,render/depth/blit
// - referenced data follows fetching command's table
// - pipeline sync write uses command's field
// - depth cache allows only unsnooped pages
`timescale 1ns/1ps
module gat_translate
  import gat_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic [PHYS_ADDR_W-1:0]     stolenBase,
  input  wire logic [PHYS_ADDR_W-1:0]     processBase,
  input  wire logic                       processEnable,
  input  wire logic [SELECT_W-1:0]        tableSelectControl,
  input  wire logic                       reqValid,
  input  wire gat_pkg::gat_client_t       reqClient,
  input  wire logic [LOG_ADDR_W-1:0]      reqAddr,
  input  wire logic                       reqCmdProcess,
  output logic                            reqReady,
  output logic                            rspValid,
  output logic [PHYS_ADDR_W-1:0]          rspAddr,
  output logic                            rspSnooped,
  output logic                            rspFault,
  output logic                            rspUsedProcess,
  input  wire logic                       updValid,
  input  wire logic [GLOBAL_IDX_W-1:0]    updIndex,
  input  wire logic [ENTRY_W-1:0]         updEntry,
  output logic                            updWrite,
  output logic [PHYS_ADDR_W-1:0]          updAddr,
  output logic [ENTRY_W-1:0]              updData,
  output logic                            memReq,
  output logic [PHYS_ADDR_W-1:0]          memAddr,
  input  wire logic                       memValid,
  input  wire logic [ENTRY_W-1:0]         memData
);
  import gat_pkg::*;
  typedef enum logic [1:0] {GAT_IDLE, GAT_FETCH, GAT_DONE} gat_state_t;
  gat_state_t state_q;
  gat_fetch_if fch();
  gat_entry_fetch u_fetch (
    .clk      (clk),
    .reset    (reset),
    .fch      (fch),
    .memReq   (memReq),
    .memAddr  (memAddr),
    .memValid (memValid),
    .memData  (memData)
  );
  // ==========================================================
  // table choice
  // ==========================================================
  logic                   selBit;
  logic                   wantProcess;
  logic                   useProcess;
  logic                   globalOnly;
  logic                   followsCmd;
  logic [PAGE_SHIFT-1:0]  pageOffset;
  logic [LOG_ADDR_W-PAGE_SHIFT-1:0] pageNum;
  logic                   inRangeGlobal;
  logic                   inRangeProcess;
  logic [PHYS_ADDR_W-1:0] globalEntryAddr;
  logic [PHYS_ADDR_W-1:0] processEntryAddr;
  logic [PHYS_ADDR_W-1:0] updEntryAddr;
  always_comb begin
    selBit     = 1'b0;
    followsCmd = 1'b0;
    globalOnly = 1'b0;
    unique case (reqClient)
      GAT_CL_HOST, GAT_CL_DISPLAY,
      GAT_CL_OVERLAY, GAT_CL_CURSOR: globalOnly = 1'b1;
      GAT_CL_RING:     selBit = tableSelectControl[SEL_RING];
      GAT_CL_BATCH:    selBit = tableSelectControl[SEL_BATCH];
      GAT_CL_INDIRECT: selBit = tableSelectControl[SEL_INDIRECT];
      GAT_CL_VERTEX:   selBit = tableSelectControl[SEL_VERTEX];
      GAT_CL_SAMPLER:  selBit = tableSelectControl[SEL_SAMPLER];
      GAT_CL_RENDER, GAT_CL_DEPTH,
      GAT_CL_BLIT:     selBit = tableSelectControl[SEL_RENDER_DATA];
      GAT_CL_CONSTANT, GAT_CL_MEDIA,
      GAT_CL_STORE_IMM: followsCmd = 1'b1;
      GAT_CL_PIPE_SYNC: followsCmd = 1'b1;
    endcase
  end
  assign wantProcess = globalOnly ? 1'b0 : (followsCmd ? reqCmdProcess : selBit);
  assign useProcess  = wantProcess && processEnable;
  assign pageOffset  = reqAddr[PAGE_SHIFT-1:0];
  assign pageNum     = reqAddr[LOG_ADDR_W-1:PAGE_SHIFT];
  // pages beyond the table extent are faults
  assign inRangeGlobal  = (pageNum < (LOG_ADDR_W-PAGE_SHIFT)'(GLOBAL_ENTRIES));
  assign inRangeProcess = (pageNum < (LOG_ADDR_W-PAGE_SHIFT)'(PROCESS_ENTRIES));
  // global table sits at offset zero of the stolen region
  assign globalEntryAddr = stolenBase + STOLEN_TABLE_OFFSET
                         + {{(PHYS_ADDR_W-LOG_ADDR_W+PAGE_SHIFT){1'b0}}, pageNum}
                           * PHYS_ADDR_W'(ENTRY_BYTES);
  assign processEntryAddr = processBase
                         + {{(PHYS_ADDR_W-LOG_ADDR_W+PAGE_SHIFT){1'b0}}, pageNum}
                           * PHYS_ADDR_W'(ENTRY_BYTES);
  assign updEntryAddr = stolenBase + STOLEN_TABLE_OFFSET
                      + {{(PHYS_ADDR_W-GLOBAL_IDX_W-ENTRY_SHIFT){1'b0}}, updIndex, 2'h0};
  // ==========================================================
  // request sequencing
  // ==========================================================
  logic [PAGE_SHIFT-1:0] offset_q;
  logic                  usedProc_q;
  logic                  depth_q;
  logic                  rangeOk;
  logic                  entValid;
  logic                  entSnoop;
  logic [FRAME_W-1:0]    entFrame;
  assign rangeOk  = useProcess ? inRangeProcess : inRangeGlobal;
  assign entValid = fch.entry[ENT_VALID];
  assign entSnoop = fch.entry[ENT_SNOOP];
  assign entFrame = FRAME_W'(fch.entry[ENT_FRAME_HI:ENT_FRAME_LO]);
  logic fetchSent_q;
  logic [PHYS_ADDR_W-1:0] fetchAddr_q;
  assign fch.req  = (state_q == GAT_FETCH) && !fetchSent_q;
  assign fch.addr = fetchAddr_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q        <= GAT_IDLE;
      reqReady       <= 1'b1;
      rspValid       <= 1'b0;
      rspAddr        <= '0;
      rspSnooped     <= 1'b0;
      rspFault       <= 1'b0;
      rspUsedProcess <= 1'b0;
      offset_q       <= '0;
      usedProc_q     <= 1'b0;
      depth_q        <= 1'b0;
      fetchSent_q    <= 1'b0;
      fetchAddr_q    <= '0;
    end else begin
      rspValid <= 1'b0;
      unique case (state_q)
        GAT_IDLE: if (reqValid && reqReady) begin
          reqReady   <= 1'b0;
          offset_q   <= pageOffset;
          usedProc_q <= useProcess;
          depth_q    <= (reqClient == GAT_CL_DEPTH);
          fetchAddr_q <= useProcess ? processEntryAddr : globalEntryAddr;
          if (rangeOk) begin
            state_q     <= GAT_FETCH;
            fetchSent_q <= 1'b0;
          end else begin
            rspValid       <= 1'b1;
            rspFault       <= 1'b1;
            rspAddr        <= '0;
            rspSnooped     <= 1'b0;
            rspUsedProcess <= useProcess;
            state_q        <= GAT_DONE;
          end
        end
        GAT_FETCH: begin
          fetchSent_q <= 1'b1;
          if (fch.done) begin
            rspValid       <= 1'b1;
            rspUsedProcess <= usedProc_q;
            rspAddr        <= {entFrame, offset_q};
            rspSnooped     <= entSnoop;
            rspFault       <= !entValid || (depth_q && entSnoop);
            state_q        <= GAT_DONE;
          end
        end
        GAT_DONE: begin
          reqReady <= 1'b1;
          state_q  <= GAT_IDLE;
        end
      endcase
    end
  end
  // ==========================================================
  // global entry updates through the aperture or update command
  // ==========================================================
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      updWrite <= 1'b0;
      updAddr  <= '0;
      updData  <= '0;
    end else begin
      updWrite <= updValid;
      if (updValid) begin
        updAddr <= updEntryAddr;
        updData <= updEntry;
      end
    end
  end
  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_take;
    reqValid && reqReady && state_q == GAT_IDLE;
  endsequence
  sequence s_entry_back;
    state_q == GAT_FETCH && fch.done;
  endsequence
  a_global_only_clients: assert property (s_take and ##0 (reqClient inside
    {GAT_CL_HOST, GAT_CL_DISPLAY, GAT_CL_OVERLAY, GAT_CL_CURSOR})
    |=> !usedProc_q) else $error("global-only client used process table");
  a_fallback_global: assert property (s_take and ##0 !processEnable |=> !usedProc_q)
    else $error("process table used while disabled");
  a_ring_select: assert property (s_take and ##0 (reqClient == GAT_CL_RING)
    && processEnable |=> usedProc_q == $past(tableSelectControl[SEL_RING]))
    else $error("ring select wrong");
  a_render_select: assert property (s_take and ##0 (reqClient == GAT_CL_BLIT)
    && processEnable |=> usedProc_q == $past(tableSelectControl[SEL_RENDER_DATA]))
    else $error("blit select wrong");
  a_cmd_follow: assert property (s_take and ##0 (reqClient == GAT_CL_CONSTANT)
    && processEnable |=> usedProc_q == $past(reqCmdProcess))
    else $error("constant data table wrong");
  a_offset_kept: assert property (s_entry_back |=> rspValid
    && rspAddr[PAGE_SHIFT-1:0] == $past(offset_q))
    else $error("page offset altered");
  a_depth_unsnooped: assert property (rspValid && depth_q && rspSnooped |-> rspFault)
    else $error("depth access on snooped page");
  a_global_limit: assert property (s_take and ##0 !useProcess && !inRangeGlobal
    |=> rspValid && rspFault) else $error("global range not enforced");
  a_update_write: assert property (updValid |=> updWrite
    && updData == $past(updEntry)) else $error("update not forwarded");
endmodule // gat_translate

// file: dv/gat_mem_model.sv
// memory path model: sparse table entries, reads answered after a set latency
// assumes one outstanding read at a time and a registered request pulse
`timescale 1ns/1ps
module gat_mem_model
  import gat_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   memReq,
  input  wire logic [PHYS_ADDR_W-1:0] memAddr,
  output logic                        memValid,
  output logic [ENTRY_W-1:0]          memData,
  input  wire logic                   updWrite,
  input  wire logic [PHYS_ADDR_W-1:0] updAddr,
  input  wire logic [ENTRY_W-1:0]     updData,
  input  wire logic [3:0]             lat
);
  import gat_pkg::*;
  logic [ENTRY_W-1:0]     mem [logic [PHYS_ADDR_W-1:0]];
  logic [PHYS_ADDR_W-1:0] lastAddr;
  int                     reads;
  // ==========================================================
  // table storage
  // ==========================================================
  always @(posedge clk) begin
    if (updWrite === 1'b1) begin
      mem[updAddr] = updData;
    end
  end
  initial begin
    memValid = 1'b0;
    memData  = 32'h00000000;
    reads    = 0;
    lastAddr = '0;
    forever begin
      @(posedge clk);
      if (memReq === 1'b1 && reset === 1'b0) begin
        lastAddr = memAddr;
        reads++;
        repeat (lat) @(posedge clk);
        memValid <= 1'b1;
        memData  <= mem.exists(lastAddr) ? mem[lastAddr] : 32'h00000000;
        @(posedge clk);
        memValid <= 1'b0;
        // released line shows the inverse, never the stale word
        memData  <= ~memData;
      end
    end
  end
endmodule // gat_mem_model

// file: dv/gat_translate_tb.sv
// self-checking bench for the translator with a memory path model
// assumes the translator's registered one-outstanding request handshake
`timescale 1ns/1ps
module gat_translate_tb;
  import gat_pkg::*;
  logic                   clk = 1'b0;
  logic                   reset = 1'b1;
  logic [PHYS_ADDR_W-1:0] stolenBase = 36'h0_8000_0000;
  logic [PHYS_ADDR_W-1:0] processBase = 36'h1_2345_6000;
  logic                   processEnable = 1'b0;
  logic [SELECT_W-1:0]    tableSelectControl = 6'h00;
  logic                   reqValid = 1'b0;
  gat_client_t            reqClient = GAT_CL_HOST;
  logic [LOG_ADDR_W-1:0]  reqAddr = 32'h00000000;
  logic                   reqCmdProcess = 1'b0;
  logic                   updValid = 1'b0;
  logic [GLOBAL_IDX_W-1:0] updIndex = 17'h00000;
  logic [ENTRY_W-1:0]     updEntry = 32'h00000000;
  logic [3:0]             lat = 4'h1;
  logic                   reqReady, rspValid, rspSnooped, rspFault, rspUsedProcess;
  logic                   updWrite, memReq, memValid;
  logic [PHYS_ADDR_W-1:0] rspAddr, updAddr, memAddr;
  logic [ENTRY_W-1:0]     updData, memData;
  logic [31:0]            lfsr = 32'h0000B78B;
  logic [31:0]            a, e;
  int                     numErrors = 0;
  int                     checksDone = 0;

  always #25 clk = ~clk;

  gat_translate dut (.clk(clk), .reset(reset), .stolenBase(stolenBase),
    .processBase(processBase), .processEnable(processEnable),
    .tableSelectControl(tableSelectControl), .reqValid(reqValid), .reqClient(reqClient),
    .reqAddr(reqAddr), .reqCmdProcess(reqCmdProcess), .reqReady(reqReady),
    .rspValid(rspValid), .rspAddr(rspAddr), .rspSnooped(rspSnooped), .rspFault(rspFault),
    .rspUsedProcess(rspUsedProcess), .updValid(updValid), .updIndex(updIndex),
    .updEntry(updEntry), .updWrite(updWrite), .updAddr(updAddr), .updData(updData),
    .memReq(memReq), .memAddr(memAddr), .memValid(memValid), .memData(memData));
  gat_mem_model mdl (.clk(clk), .reset(reset), .memReq(memReq), .memAddr(memAddr),
    .memValid(memValid), .memData(memData), .updWrite(updWrite), .updAddr(updAddr),
    .updData(updData), .lat(lat));

  // ==========================================================
  // helpers
  // ==========================================================
  function void step();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h00400007 : 32'h00000000);
  endfunction
  function automatic logic expProc(gat_client_t c, logic [5:0] s, logic en, logic cp);
    logic u;
    case (c)
      GAT_CL_RING:     u = s[2];
      GAT_CL_BATCH:    u = s[5];
      GAT_CL_INDIRECT: u = s[4];
      GAT_CL_VERTEX:   u = s[3];
      GAT_CL_SAMPLER:  u = s[1];
      GAT_CL_RENDER, GAT_CL_DEPTH, GAT_CL_BLIT: u = s[0];
      GAT_CL_CONSTANT, GAT_CL_MEDIA, GAT_CL_STORE_IMM: u = cp;
      GAT_CL_PIPE_SYNC: u = cp;
      default: u = 1'b0;
    endcase
    return u & en;
  endfunction
  task automatic check(string what, logic [35:0] exp, logic [35:0] got);
    checksDone++;
    if (got !== exp) begin
      numErrors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic closeOut();
    $display("checks %0d errors %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // one translation; pre places the entry in memory first
  task automatic xlate(gat_client_t c, logic [31:0] la, logic [31:0] ent, logic cp, logic pre);
    logic up, oor, flt;
    logic [35:0] ea;
    int r0, n;
    @(posedge clk);
    up = expProc(c, tableSelectControl, processEnable, cp);
    oor = up ? la[31] : (la[31:29] != 3'h0);
    ea = (up ? processBase : stolenBase) + 36'({la[31:12], 2'b00});
    if (pre && !oor) mdl.mem[ea] = ent;
    flt = oor || !ent[0] || (c == GAT_CL_DEPTH && ent[1]);
    r0 = mdl.reads;
    reqValid <= 1'b1;
    reqClient <= c;
    reqAddr <= la;
    reqCmdProcess <= cp;
    @(posedge clk);
    reqValid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rspValid !== 1'b1 && n < 40);
    if (rspValid !== 1'b1) begin
      numErrors++;
      $display("ERROR rspValid expected 1 seen %b", rspValid);
      closeOut();
    end else begin
      check("reqReady", 36'h0, 36'(reqReady));
      check("rspFault", 36'(flt), 36'(rspFault));
      check("memReads", 36'(oor ? r0 : r0 + 1), 36'(mdl.reads));
      if (!oor) check("memAddr", ea, mdl.lastAddr);
      if (!flt) begin
        check("rspAddr", {4'h0, ent[31:12], la[11:0]}, rspAddr);
        check("rspSnooped", 36'(ent[1]), 36'(rspSnooped));
        check("rspUsedProcess", 36'(up), 36'(rspUsedProcess));
      end
    end
  endtask
  task automatic upd(logic [16:0] i, logic [31:0] ent);
    int n;
    @(posedge clk);
    updValid <= 1'b1;
    updIndex <= i;
    updEntry <= ent;
    @(posedge clk);
    updValid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (updWrite !== 1'b1 && n < 3);
    check("updWrite", 36'h1, 36'(updWrite));
    check("updAddr", stolenBase + 36'({i, 2'b00}), updAddr);
    check("updData", 36'(ent), 36'(updData));
  endtask

  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    check("reqReady", 36'h1, 36'(reqReady));
    check("outputs", 36'h0, 36'({rspValid, memReq, updWrite}));
    @(posedge clk);
    reset <= 1'b0;
    upd(17'h1FFFF, 32'hABCDE003);
    repeat (2) @(posedge clk); // fence before the new mapping is used
    xlate(GAT_CL_HOST, 32'h1FFFFABC, 32'hABCDE003, 1'b0, 1'b0);
    xlate(GAT_CL_DISPLAY, 32'h20000000, 32'h00001001, 1'b0, 1'b1);
    @(posedge clk);
    processEnable <= 1'b1;
    tableSelectControl <= 6'h3F;
    xlate(GAT_CL_RING, 32'h7FFFF123, 32'h55555001, 1'b0, 1'b1);
    xlate(GAT_CL_BATCH, 32'h80000000, 32'h55555001, 1'b0, 1'b1);
    xlate(GAT_CL_CURSOR, 32'h00004010, 32'h77777001, 1'b1, 1'b1);
    xlate(GAT_CL_DEPTH, 32'h00005000, 32'h66666003, 1'b0, 1'b1);
    xlate(GAT_CL_BLIT, 32'h00005000, 32'h66666003, 1'b0, 1'b1);
    for (int k = 0; k < 300; k++) begin
      step();
      @(posedge clk);
      tableSelectControl <= lfsr[5:0];
      processEnable <= lfsr[6];
      lat <= {1'b0, lfsr[9:7]};
      processBase <= {lfsr[31:8], 12'h000};
      step();
      a = lfsr;
      if (a[4:2] != 3'h0) a[31:29] = 3'h0;
      step();
      e = lfsr;
      if (e[3:2] != 2'h0) e[0] = 1'b1;
      xlate(gat_client_t'(k[3:0]), a, e, a[7], 1'b1);
    end
    closeOut();
  end
endmodule // gat_translate_tb
